/* File: design/bsps_pkg.sv */
/*
  Shared constants, helper functions and types for the split-port burst SRAM link.
  Assumes both ends run on one core clock and that every core clock edge stands
  for at most one rising edge of either the positive or the complementary link clock.
*/
package bsps_pkg;

  localparam int ORG_BITS = 18;
  localparam int ADDR_BITS = 8;
  localparam int BURST_WORDS = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int NIBBLE_LANE_BITS = 4;
  localparam int BYTE_LANE_BITS = 9;
  localparam int NIBBLE_ORG_BITS = 8;

  // Link timing in positive clock cycles after the command edge.
  localparam int WR_DATA_DELAY_K = 1;
  localparam int RD_LATENCY_K = 2;

  // Same timing seen from the controller in core edges after issue: two core edges
  // per link cycle, and one edge spent in the device's input registers.
  localparam int WR_DRV_TAP = 2 * WR_DATA_DELAY_K - 1;
  localparam int RD_CAP_TAP = 2 * RD_LATENCY_K + 1;
  localparam int HIST_LEN = RD_CAP_TAP + BURST_WORDS;

  typedef enum logic [1:0] {CLK_RUN, CLK_PARKED, CLK_RESUME} bsps_clk_state_e;

  function automatic int lane_bits(input int org);
    return (org == NIBBLE_ORG_BITS) ? NIBBLE_LANE_BITS : BYTE_LANE_BITS;
  endfunction : lane_bits

  function automatic int lane_count(input int org);
    return org / lane_bits(org);
  endfunction : lane_count

endpackage : bsps_pkg

/* File: design/bsps_link_if.sv */
/*
  Link between the memory controller and the burst SRAM device.
  Assumes a single core clock; q carries meaning only while q_oe is high, and
  q_oe low stands for the floating read outputs.
*/
interface bsps_link_if #(
  parameter int DW = bsps_pkg::ORG_BITS,
  parameter int NS = bsps_pkg::lane_count(bsps_pkg::ORG_BITS),
  parameter int AW = bsps_pkg::ADDR_BITS
);
  logic k;
  logic k_n;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] d;
  logic [NS-1:0] byte_write_select_n;
  logic [DW-1:0] q;
  logic q_oe;

  modport device (
    input k, k_n, read_port_select_n, write_port_select_n, addr, d, byte_write_select_n,
    output q, q_oe
  );

  modport ctrl (
    output k, k_n, read_port_select_n, write_port_select_n, addr, d, byte_write_select_n,
    input q, q_oe
  );
endinterface : bsps_link_if

/* File: design/bsps_fifo.sv */
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock; the head word is presented from the storage flops.
*/
module bsps_fifo #(
  parameter int W = 8,
  parameter int DEPTH = bsps_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] store_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = store_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end
endmodule : bsps_fifo

/* File: design/bsps_mem_ctrl.sv */
/*
  Controller end of the burst SRAM link: makes the link clock pair, issues read
  and write bursts from a command FIFO, drives write words and collects read words.
  Assumes the device on the far side shares core_clk and resetn.
*/
module bsps_mem_ctrl #(
  parameter int ORG_BITS = bsps_pkg::ORG_BITS,
  parameter int ADDR_W = bsps_pkg::ADDR_BITS,
  parameter int FIFO_DEPTH = bsps_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link to the device
  bsps_link_if.ctrl lnk,
  // Command requests
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [bsps_pkg::BURST_WORDS*ORG_BITS-1:0] req_wdata,
  input wire logic [bsps_pkg::BURST_WORDS*bsps_pkg::lane_count(ORG_BITS)-1:0] req_mask_n,
  // Read returns
  output logic rd_valid,
  output logic [bsps_pkg::BURST_WORDS*ORG_BITS-1:0] rd_data,
  // Standby
  input wire logic stop_req,
  output logic clk_parked
);
  localparam int DW = ORG_BITS;
  localparam int NS = bsps_pkg::lane_count(ORG_BITS);
  localparam int BN = bsps_pkg::BURST_WORDS;
  localparam int HL = bsps_pkg::HIST_LEN;
  localparam int FW = 1 + ADDR_W + BN * (DW + NS);

  bsps_pkg::bsps_clk_state_e clk_state_reg;
  logic k_reg;
  logic kn_reg;
  logic last_rd_reg;
  logic last_wr_reg;
  logic [HL-1:0] rd_sr_reg;
  logic [HL-1:0] wr_sr_reg;
  logic [BN*DW-1:0] wp_data_reg;
  logic [BN*NS-1:0] wp_mask_reg;
  logic [BN*DW-1:0] wa_data_reg;
  logic [BN*NS-1:0] wa_mask_reg;
  logic rps_n_reg;
  logic wps_n_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DW-1:0] d_reg;
  logic [NS-1:0] bws_n_reg;
  logic rd_valid_reg;
  logic [BN*DW-1:0] rd_data_reg;
  logic f_valid;
  logic [FW-1:0] f_data;
  logic k_raise;
  logic park_go;
  logic allowed;
  logic issue_rd;
  logic issue_wr;

  bsps_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_write, req_addr, req_wdata, req_mask_n}),
    .out_valid(f_valid),
    .out_ready(issue_rd | issue_wr),
    .out_data(f_data)
  );

  // This edge raises the positive clock, so commands go out with it.
  assign k_raise = (clk_state_reg == bsps_pkg::CLK_RUN) && !k_reg;
  assign park_go = k_raise && stop_req && (rd_sr_reg == '0) && (wr_sr_reg == '0);
  assign allowed = k_raise && !stop_req && f_valid;
  assign issue_rd = allowed && !f_data[FW-1] && !last_rd_reg;
  assign issue_wr = allowed && f_data[FW-1] && !last_wr_reg;

  // Parking holds both clocks high for the quickest restart; a park only happens
  // once every burst has drained, so the device loses nothing while stopped.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      clk_state_reg <= bsps_pkg::CLK_RUN;
      k_reg <= 1'b0;
      kn_reg <= 1'b1;
    end else begin
      case (clk_state_reg)
        bsps_pkg::CLK_RUN: begin
          if (park_go) begin
            k_reg <= 1'b1;
            kn_reg <= 1'b1;
            clk_state_reg <= bsps_pkg::CLK_PARKED;
          end else begin
            k_reg <= ~k_reg;
            kn_reg <= k_reg;
          end
        end
        bsps_pkg::CLK_PARKED: begin
          if (!stop_req) begin
            kn_reg <= 1'b0;
            clk_state_reg <= bsps_pkg::CLK_RESUME;
          end
        end
        bsps_pkg::CLK_RESUME: begin
          k_reg <= 1'b0;
          kn_reg <= 1'b1;
          clk_state_reg <= bsps_pkg::CLK_RUN;
        end
        default: begin
          clk_state_reg <= bsps_pkg::CLK_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      last_rd_reg <= 1'b0;
      last_wr_reg <= 1'b0;
      rps_n_reg <= 1'b1;
      wps_n_reg <= 1'b1;
      addr_reg <= '0;
    end else begin
      if (k_raise) begin
        last_rd_reg <= issue_rd;
        last_wr_reg <= issue_wr;
      end
      rps_n_reg <= ~issue_rd;
      wps_n_reg <= ~issue_wr;
      if (issue_rd || issue_wr) begin
        addr_reg <= f_data[FW-2 -: ADDR_W];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_sr_reg <= '0;
      wr_sr_reg <= '0;
    end else begin
      rd_sr_reg <= {rd_sr_reg[HL-2:0], issue_rd};
      wr_sr_reg <= {wr_sr_reg[HL-2:0], issue_wr};
    end
  end

  // The next write may be issued while the current one still streams, so its
  // words wait in a pending copy until its own first data slot.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wp_data_reg <= '0;
      wp_mask_reg <= '1;
      wa_data_reg <= '0;
      wa_mask_reg <= '1;
      d_reg <= '0;
      bws_n_reg <= '1;
    end else begin
      if (issue_wr) begin
        wp_data_reg <= f_data[BN*(DW+NS)-1 -: BN*DW];
        wp_mask_reg <= f_data[BN*NS-1:0];
      end
      if (wr_sr_reg[bsps_pkg::WR_DRV_TAP]) begin
        d_reg <= wp_data_reg[DW-1:0];
        bws_n_reg <= wp_mask_reg[NS-1:0];
        wa_data_reg <= wp_data_reg >> DW;
        wa_mask_reg <= wp_mask_reg >> NS;
      end else if (|wr_sr_reg[bsps_pkg::WR_DRV_TAP+1 +: BN-1]) begin
        d_reg <= wa_data_reg[DW-1:0];
        bws_n_reg <= wa_mask_reg[NS-1:0];
        wa_data_reg <= wa_data_reg >> DW;
        wa_mask_reg <= wa_mask_reg >> NS;
      end else begin
        d_reg <= '0;
        bws_n_reg <= '1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_data_reg <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      for (int i = 0; i < BN; i++) begin
        if (rd_sr_reg[bsps_pkg::RD_CAP_TAP+i]) begin
          rd_data_reg[i*DW +: DW] <= lnk.q;
        end
      end
      rd_valid_reg <= rd_sr_reg[bsps_pkg::RD_CAP_TAP+BN-1];
    end
  end

  assign lnk.k = k_reg;
  assign lnk.k_n = kn_reg;
  assign lnk.read_port_select_n = rps_n_reg;
  assign lnk.write_port_select_n = wps_n_reg;
  assign lnk.addr = addr_reg;
  assign lnk.d = d_reg;
  assign lnk.byte_write_select_n = bws_n_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;
  assign clk_parked = (clk_state_reg == bsps_pkg::CLK_PARKED);
endmodule : bsps_mem_ctrl

/* File: design/bsps_sram_dev.sv */
/*
  Device end of the burst SRAM link: a split-port memory with four-word bursts,
  double-rate write data with lane selects and double-rate read data.
  Assumes the link clocks arrive as levels sampled on core_clk, one link clock
  rise per core edge at most, and resetn stands in for power-up.
*/
module bsps_sram_dev #(
  parameter int ORG_BITS = bsps_pkg::ORG_BITS,
  parameter int ADDR_W = bsps_pkg::ADDR_BITS
) (
  // Clock and power-up reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link to the controller
  bsps_link_if.device lnk,
  // Status
  output logic rd_busy,
  output logic wr_busy
);
  // Lane width and count follow the organisation.
  localparam int DW = ORG_BITS;
  localparam int LW = bsps_pkg::lane_bits(ORG_BITS);
  localparam int NS = bsps_pkg::lane_count(ORG_BITS);
  localparam int BW = $clog2(bsps_pkg::BURST_WORDS);
  localparam logic [BW-1:0] LAST_IDX = BW'(bsps_pkg::BURST_WORDS - 1);

  logic [DW-1:0] mem [2**ADDR_W];

  logic k_last_reg;
  logic kn_last_reg;
  logic rd_prev_reg;
  logic wr_prev_reg;
  logic s1_v_reg;
  logic [ADDR_W-1:0] s1_a_reg;
  logic s2_v_reg;
  logic [ADDR_W-1:0] s2_a_reg;
  logic rb_act_reg;
  logic [BW-1:0] rb_idx_reg;
  logic [ADDR_W-1:0] rb_base_reg;
  logic [DW-1:0] q_reg;
  logic q_oe_reg;
  logic wp_v_reg;
  logic [ADDR_W-1:0] wp_a_reg;
  logic wb_act_reg;
  logic [BW-1:0] wb_idx_reg;
  logic [ADDR_W-1:0] wb_base_reg;

  logic k_rise;
  logic kn_rise;
  logic any_rise;
  logic rd_go;
  logic wr_go;
  logic [ADDR_W-1:0] rd_word_addr;
  logic wr_first;
  logic wr_cont;
  logic [ADDR_W-1:0] wr_addr;
  logic [DW-1:0] wr_old;
  logic [DW-1:0] wr_merged;
  logic wr_any_lane;

  // The controller drives both clocks from flops on core_clk, so no
  // synchroniser is needed. A parked pair produces no rise, so all state holds.
  assign k_rise = lnk.k & ~k_last_reg;
  assign kn_rise = lnk.k_n & ~kn_last_reg;
  assign any_rise = k_rise | kn_rise;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      k_last_reg <= 1'b1;
      kn_last_reg <= 1'b1;
    end else begin
      k_last_reg <= lnk.k;
      kn_last_reg <= lnk.k_n;
    end
  end

  // Selects count only on positive rises. A port that started at the previous
  // rise ignores its select now, and with both ports asking the read wins unless
  // a read started at the previous rise.
  assign rd_go = k_rise & ~lnk.read_port_select_n & ~rd_prev_reg;
  assign wr_go = k_rise & ~lnk.write_port_select_n & ~wr_prev_reg & ~rd_go;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
    end else if (k_rise) begin
      rd_prev_reg <= rd_go;
      wr_prev_reg <= wr_go;
    end
  end

  // Read address moves one stage per positive rise so that the first word
  // leaves on the second rise after the command.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s1_v_reg <= 1'b0;
      s1_a_reg <= '0;
      s2_v_reg <= 1'b0;
      s2_a_reg <= '0;
    end else if (k_rise) begin
      s1_v_reg <= rd_go;
      if (rd_go) begin
        s1_a_reg <= lnk.addr;
      end
      s2_v_reg <= s1_v_reg;
      s2_a_reg <= s1_a_reg;
    end
  end

  assign rd_word_addr = rb_base_reg + ADDR_W'(rb_idx_reg);

  // Outputs float from power-up until the first burst, and again at the first
  // positive rise that finds no burst left to drive.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q_reg <= '0;
      q_oe_reg <= 1'b0;
      rb_act_reg <= 1'b0;
      rb_idx_reg <= '0;
      rb_base_reg <= '0;
    end else if (k_rise && s2_v_reg) begin
      q_reg <= mem[s2_a_reg];
      q_oe_reg <= 1'b1;
      rb_base_reg <= s2_a_reg;
      rb_idx_reg <= BW'(1);
      rb_act_reg <= 1'b1;
    end else if (any_rise && rb_act_reg) begin
      q_reg <= mem[rd_word_addr];
      rb_idx_reg <= rb_idx_reg + BW'(1);
      if (rb_idx_reg == LAST_IDX) begin
        rb_act_reg <= 1'b0;
      end
    end else if (k_rise) begin
      q_oe_reg <= 1'b0;
    end
  end

  // A write address waits one positive rise, then its words arrive on the
  // next four rises of either clock.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wp_v_reg <= 1'b0;
      wp_a_reg <= '0;
    end else if (k_rise) begin
      wp_v_reg <= wr_go;
      if (wr_go) begin
        wp_a_reg <= lnk.addr;
      end
    end
  end

  assign wr_first = k_rise & wp_v_reg;
  assign wr_cont = any_rise & wb_act_reg & ~wr_first;
  assign wr_addr = wr_first ? wp_a_reg : wb_base_reg + ADDR_W'(wb_idx_reg);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wb_act_reg <= 1'b0;
      wb_idx_reg <= '0;
      wb_base_reg <= '0;
    end else if (wr_first) begin
      wb_base_reg <= wp_a_reg;
      wb_idx_reg <= BW'(1);
      wb_act_reg <= 1'b1;
    end else if (wr_cont) begin
      wb_idx_reg <= wb_idx_reg + BW'(1);
      if (wb_idx_reg == LAST_IDX) begin
        wb_act_reg <= 1'b0;
      end
    end
  end

  // Each word merges with the stored word lane by lane, using the selects that
  // came with that very word; a high select keeps the old lane.
  assign wr_old = mem[wr_addr];

  for (genvar l = 0; l < NS; l++) begin : g_lane
    assign wr_merged[l*LW +: LW] = lnk.byte_write_select_n[l] ?
      wr_old[l*LW +: LW] : lnk.d[l*LW +: LW];
  end

  // Write data outside a burst never reaches the array.
  assign wr_any_lane = ~&lnk.byte_write_select_n;

  always_ff @(posedge core_clk) begin
    if ((wr_first || wr_cont) && wr_any_lane) begin
      mem[wr_addr] <= wr_merged;
    end
  end

  assign lnk.q = q_reg;
  assign lnk.q_oe = q_oe_reg;
  assign rd_busy = s1_v_reg | s2_v_reg | rb_act_reg;
  assign wr_busy = wp_v_reg | wb_act_reg;
endmodule : bsps_sram_dev

/* File: verif/bsps_link_props.sv */
/*
  Concurrent checks on the controller-to-device link of the burst SRAM pair.
  Assumes it is instantiated beside the link interface and shares its core clock.
*/
module bsps_link_props #(
  parameter int DW = 18,
  parameter int NS = 2,
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link
  input wire logic k,
  input wire logic k_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] d,
  input wire logic [NS-1:0] byte_write_select_n,
  input wire logic [DW-1:0] q,
  input wire logic q_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  logic k_reg;
  logic rd_prev_reg;
  logic wr_prev_reg;
  logic kr;
  logic rd_req;
  logic wr_req;
  logic rd_start;
  logic wr_start;
  assign kr = k && !k_reg;
  assign rd_req = kr && !read_port_select_n;
  assign wr_req = kr && !write_port_select_n;
  assign rd_start = rd_req && !rd_prev_reg;
  assign wr_start = wr_req && !wr_prev_reg && !rd_start;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      k_reg <= 1'b0;
    end else begin
      k_reg <= k;
    end
  end
  // Starts are remembered per K rise, since only consecutive rises forbid a repeat.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
    end else if (kr) begin
      rd_prev_reg <= rd_start;
      wr_prev_reg <= wr_start;
    end
  end
  oe_after_reset_a: assert property ($rose(resetn) |-> !q_oe)
    else $error("read outputs driven right after reset");
  read_latency_a: assert property (rd_start |-> ##5 q_oe [*4])
    else $error("read words not driven two cycles after the command");
  oe_cause_a: assert property ($rose(q_oe) |-> $past(rd_start, 5))
    else $error("read outputs enabled without a read start");
  oe_release_a: assert property (rd_start ##4 !rd_req |-> ##5 !q_oe)
    else $error("read outputs not released after the burst");
  write_idle_a: assert property (
    wr_start ##4 !wr_req |-> ##2 (&byte_write_select_n && d == '0))
    else $error("write lanes not released after the burst");
  select_pulse_a: assert property ((!read_port_select_n || !write_port_select_n) |->
    kr ##1 (read_port_select_n && write_port_select_n))
    else $error("port select outside a single K rise");
  read_spacing_a: assert property (rd_req |-> ##2 !rd_req)
    else $error("reads on consecutive K rises");
  write_spacing_a: assert property (wr_req |-> ##2 !wr_req)
    else $error("writes on consecutive K rises");
  joint_select_a: assert property (!(!read_port_select_n && !write_port_select_n))
    else $error("both port selects low together");
  parked_quiet_a: assert property ((k && k_n && $past(k) && $past(k_n)) |->
    (read_port_select_n && write_port_select_n))
    else $error("command issued while clocks are parked");
endmodule : bsps_link_props

/* File: verif/testbench.sv */
/*
  Self-checking bench for the burst SRAM controller and device pair.
  Assumes the design package and link interface are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DW = bsps_pkg::ORG_BITS;
  localparam int LB = bsps_pkg::BYTE_LANE_BITS;
  localparam int NS = DW / LB;
  localparam int WW = bsps_pkg::BURST_WORDS * DW;
  localparam int MW = bsps_pkg::BURST_WORDS * NS;
  logic core_clk;
  logic resetn;
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic [7:0] req_addr;
  logic [WW-1:0] req_wdata;
  logic [MW-1:0] req_mask_n;
  logic rd_valid;
  logic [WW-1:0] rd_data;
  logic stop_req;
  logic clk_parked;
  logic rd_busy;
  logic wr_busy;
  logic rd_busy_2;
  logic wr_busy_2;
  logic saw_full;
  logic [DW-1:0] mem [256];
  logic [WW-1:0] exp_q [$];
  int n_errors = 0;
  int checks_done = 0;
  bsps_link_if #(.DW(DW), .NS(NS), .AW(8)) lnk ();
  bsps_link_if #(.DW(DW), .NS(NS), .AW(8)) lnk_2 ();
  bsps_mem_ctrl i_bsps_mem_ctrl (.core_clk(core_clk), .resetn(resetn), .lnk(lnk),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_mask_n(req_mask_n),
    .rd_valid(rd_valid), .rd_data(rd_data), .stop_req(stop_req), .clk_parked(clk_parked));
  bsps_sram_dev i_bsps_sram_dev (.core_clk(core_clk), .resetn(resetn), .lnk(lnk),
    .rd_busy(rd_busy), .wr_busy(wr_busy));
  // Second device is driven by hand so that forbidden link sequences can be sent.
  bsps_sram_dev i_bsps_sram_dev_2 (.core_clk(core_clk), .resetn(resetn), .lnk(lnk_2),
    .rd_busy(rd_busy_2), .wr_busy(wr_busy_2));
  bsps_link_props #(.DW(DW), .NS(NS), .AW(8)) i_bsps_link_props (.core_clk(core_clk),
    .resetn(resetn), .k(lnk.k), .k_n(lnk.k_n), .read_port_select_n(lnk.read_port_select_n),
    .write_port_select_n(lnk.write_port_select_n), .addr(lnk.addr), .d(lnk.d),
    .byte_write_select_n(lnk.byte_write_select_n), .q(lnk.q), .q_oe(lnk.q_oe));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [WW-1:0] seen, input logic [WW-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask : step
  task automatic give_up(input int n, input int lim);
    if (n > lim) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : give_up
  // Holds the request up on return, so back-to-back calls keep valid asserted.
  task automatic issue(input logic wr, input logic [7:0] a, input logic [WW-1:0] wd,
                       input logic [MW-1:0] mk);
    int n;
    logic [WW-1:0] e;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = wd;
    req_mask_n = mk;
    n = 0;
    while (req_ready !== 1'b1) begin
      saw_full = 1'b1;
      step();
      n++;
      give_up(n, 100);
    end
    step();
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < NS; j++) begin
        if (wr && !mk[i*NS+j]) begin
          mem[8'(a + i)][j*LB +: LB] = wd[i*DW+j*LB +: LB];
        end
      end
      e[i*DW +: DW] = mem[8'(a + i)];
    end
    if (!wr) begin
      exp_q.push_back(e);
    end
  endtask : issue
  // Waits for the pair to go quiet, which also keeps reads clear of unfinished writes.
  task automatic drain;
    int n;
    int quiet;
    n = 0;
    quiet = 0;
    req_valid = 1'b0;
    while (quiet < 8) begin
      step();
      n++;
      give_up(n, 400);
      quiet = (exp_q.size() == 0 && rd_busy === 1'b0 && wr_busy === 1'b0) ? quiet + 1 : 0;
    end
  endtask : drain
  task automatic krise(input logic rs, input logic ws);
    step();
    lnk_2.k = 1'b1;
    lnk_2.k_n = 1'b0;
    lnk_2.read_port_select_n = rs;
    lnk_2.write_port_select_n = ws;
    step();
    lnk_2.k = 1'b0;
    lnk_2.k_n = 1'b1;
    lnk_2.read_port_select_n = 1'b1;
    lnk_2.write_port_select_n = 1'b1;
  endtask : krise
  // Keeps the hand-driven link clocks running, since the device only moves on their rises.
  task automatic count_oe(output int n);
    n = 0;
    repeat (7) begin
      step();
      n += (lnk_2.q_oe === 1'b1) ? 1 : 0;
      lnk_2.k = 1'b1;
      lnk_2.k_n = 1'b0;
      step();
      n += (lnk_2.q_oe === 1'b1) ? 1 : 0;
      lnk_2.k = 1'b0;
      lnk_2.k_n = 1'b1;
    end
  endtask : count_oe
  always @(negedge core_clk) begin
    if (resetn === 1'b1 && rd_valid === 1'b1) begin
      check(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : {WW{1'bx}});
    end
  end
  initial begin
    int n;
    logic [WW-1:0] w;
    resetn = 1'b0;
    {req_valid, req_write, req_addr, req_wdata, stop_req, saw_full} = '0;
    req_mask_n = '1;
    {lnk_2.k, lnk_2.k_n, lnk_2.read_port_select_n, lnk_2.write_port_select_n} = 4'h7;
    lnk_2.addr = 8'h33;
    lnk_2.d = '0;
    lnk_2.byte_write_select_n = '1;
    repeat (3) step();
    resetn = 1'b1;
    step();
    check(lnk.q_oe, 1'b0);
    w = {18'h3a5a5, 18'h0c3c3, 18'h12345, 18'h2fedc};
    issue(1'b1, 8'hfe, w, '0);
    drain();
    issue(1'b0, 8'hfe, '0, '0);
    drain();
    issue(1'b1, 8'hfe, ~w, 8'h1e);
    drain();
    issue(1'b0, 8'hfe, '0, '0);
    drain();
    for (int i = 0; i < 6; i++) begin
      issue(1'b1, 8'h20 + 8'(i * 8), {4{18'(i * 18'h0f0f1)}}, '0);
    end
    drain();
    check(saw_full, 1'b1);
    for (int i = 5; i >= 0; i--) begin
      issue(1'b0, 8'h20 + 8'(i * 8), '0, '0);
    end
    drain();
    stop_req = 1'b1;
    n = 0;
    while (clk_parked !== 1'b1) begin
      step();
      n++;
      give_up(n, 200);
    end
    repeat (6) step();
    check({lnk.k, lnk.k_n}, 2'h3);
    stop_req = 1'b0;
    issue(1'b0, 8'hfe, '0, '0);
    drain();
    krise(1'b0, 1'b1);
    krise(1'b0, 1'b1);
    count_oe(n);
    check(n, 4);
    krise(1'b1, 1'b1);
    krise(1'b0, 1'b0);
    check({rd_busy_2, wr_busy_2}, 2'h2);
    count_oe(n);
    check({n, wr_busy_2}, {32'd4, 1'b0});
    tally_and_finish();
  end
endmodule : testbench
